// ### include/acs_pkg.sv
// Shared constants, strap encodings and carrier types of the compensation sequencer.
// Assumes a front end that turns the strap resistor into a code 0..34.
// Operation
// RULE1: Strap low keeps compensation fully disabled
// RULE2: Decode strap into store, repeat, power-good, gain
// RULE3: Run once after ramp, or periodically
// RULE4: Store results, return them on readback
// RULE5: Repeat mode stores only first run
// RULE6: Apply stored values on later start-ups
// RULE7: Repeat mode uses latest computed results
// RULE8: Refuse store disable while output enabled
// RULE9: Control command while enabled forces next store
// RULE10: Disabled compensation uses default or user taps
// RULE11: Delay option: power-good first, then compensation
// RULE12: Host keeps power-good delay beyond ramp
// RULE13: After-comp option: power-good after first run
// RULE14: Scale results by full or half gain
// RULE15: Host provides minimum turn-on delay
// RULE16: System keeps input voltage stable first
// RULE17: Host configures and triggers over serial bus
// RULE18: Fixed dead-time between high and low drives
// RULE19: Strap sampled once after reset, kept
// RULE20: No run before ramp done and regulating
package acs_pkg;
    localparam logic [63:0] CLK_HZ           = 64'd200_000_000;
    localparam logic [63:0] SHORT_PERIOD_MS  = 64'd1000;
    localparam logic [63:0] LONG_PERIOD_S    = 64'd60;
    localparam logic [35:0] SHORT_PERIOD_CYC = 36'(CLK_HZ * SHORT_PERIOD_MS / 64'd1000);
    localparam logic [35:0] LONG_PERIOD_CYC  = 36'(CLK_HZ * LONG_PERIOD_S);
    localparam logic [63:0] DEAD_TIME_NS     = 64'd20;
    localparam logic [3:0]  DEAD_CYC         = 4'((DEAD_TIME_NS * CLK_HZ + 64'd999_999_999)
                                                  / 64'd1_000_000_000);
    localparam logic [5:0]  STRAP_LOW        = 6'h00;
    localparam logic [5:0]  STRAP_OPEN       = 6'h01;
    localparam logic [5:0]  STRAP_HIGH       = 6'h02;
    localparam logic [5:0]  STRAP_RES_BASE   = 6'h03;
    localparam int          BIT_STORE        = 0;
    localparam int          BIT_REPEAT       = 1;
    localparam int          BIT_PG_DELAY     = 2;
    localparam int          BIT_LONG         = 3;
    localparam int          BIT_HALF         = 4;

    typedef struct packed {
        logic enable;
        logic store;
        logic repeat_run;
        logic pg_after_delay;
        logic long_period;
        logic half_gain;
    } acs_cfg_t;

    typedef struct packed {
        logic signed [15:0] kp;
        logic signed [15:0] ki;
        logic signed [15:0] kd;
    } acs_taps_t;

    localparam acs_cfg_t  CFG_RESET  = '{default: 1'b0};
    localparam acs_taps_t TAPS_RESET = '{default: 16'h0000};
endpackage

// ### src/acs_deadtime.sv
// Gate drive with a fixed dead-time between high-side and low-side turn-on.
// Assumes the PWM request is synchronous to clk.
`timescale 1ns/1ps
module acs_deadtime (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pwm_high,
    output logic      hs_gate,
    output logic      ls_gate
);
    import acs_pkg::*;

    typedef struct packed {
        logic       side;
        logic [3:0] cnt;
        logic       hs;
        logic       ls;
    } acs_dt_st_t;

    acs_dt_st_t st_q;
    acs_dt_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (pwm_high != st_q.side) begin
            // Both off first, so a switch never overlaps the other
            st_d.side = pwm_high;
            st_d.cnt  = DEAD_CYC; // RULE18
            st_d.hs   = 1'b0;
            st_d.ls   = 1'b0;
        end else if (st_q.cnt != 4'h0) begin
            st_d.cnt = st_q.cnt - 4'h1;
        end else begin
            st_d.hs = st_q.side;
            st_d.ls = !st_q.side;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{side: 1'b0, cnt: DEAD_CYC, hs: 1'b0, ls: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign hs_gate = st_q.hs;
    assign ls_gate = st_q.ls;

    no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n) !(hs_gate && ls_gate)) // RULE18
        else $error("both gates on");
    dead_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
        $fell(ls_gate) |-> !hs_gate [*4])
        else $error("dead-time too short");
    cover_switch_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(hs_gate));
endmodule // acs_deadtime

// ### src/acs_sequencer.sv
// Compensation sequencer: strap decode, run scheduling, gain, store and power-good.
// Assumes the tuning engine, store and power stage sit outside, synchronous to clk.
`timescale 1ns/1ps
module acs_sequencer #(
    parameter logic [35:0] SHORT_CYC = acs_pkg::SHORT_PERIOD_CYC,
    parameter logic [35:0] LONG_CYC  = acs_pkg::LONG_PERIOD_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [5:0]        comp_config_strap_pin,
    input  wire logic              strap_valid,
    input  wire logic              cfg_wr,
    input  wire acs_pkg::acs_cfg_t cfg_wdata,
    input  wire logic              tuning_control_cmd_alias,
    input  wire logic              filter_tap_readback_cmd,
    input  wire logic              output_enable,
    input  wire logic              ramp_done,
    input  wire logic              pg_delay_done,
    input  wire logic              comp_done,
    input  wire acs_pkg::acs_taps_t comp_taps,
    input  wire logic              nvm_valid,
    input  wire acs_pkg::acs_taps_t nvm_taps,
    input  wire acs_pkg::acs_taps_t default_taps,
    input  wire logic              pwm_high,
    output acs_pkg::acs_cfg_t      cfg,
    output logic                   cfg_refused,
    output logic                   comp_start,
    output acs_pkg::acs_taps_t     active_taps,
    output logic                   nvm_wr,
    output logic                   nvm_erase,
    output acs_pkg::acs_taps_t     nvm_wdata,
    output logic                   readback_valid,
    output acs_pkg::acs_taps_t     readback_taps,
    output logic                   power_good_output,
    output logic                   hs_gate,
    output logic                   ls_gate
);
    import acs_pkg::*;

    typedef enum logic [2:0] {S_OFF, S_RAMP, S_PGDLY, S_COMP, S_REG} acs_state_t;

    typedef struct packed {
        acs_state_t state;
        acs_cfg_t   cfg;
        logic       strap_taken;
        logic       first_done;
        logic       store_next;
        logic [35:0] period_cnt;
        acs_taps_t  taps;
        acs_taps_t  nvm_wdata;
        acs_taps_t  rb_taps;
        logic       rb_valid;
        logic       start;
        logic       wr;
        logic       erase;
        logic       refused;
        logic       pg;
    } acs_st_t;

    acs_st_t st_q;
    acs_st_t st_d;

    function automatic acs_cfg_t decode_strap(input logic [5:0] code);
        acs_cfg_t   c;
        logic [5:0] i;
        c = CFG_RESET;
        i = code - STRAP_RES_BASE;
        if (code == STRAP_LOW) begin
            c = CFG_RESET; // RULE1
        end else if (code == STRAP_OPEN || code == STRAP_HIGH) begin
            c.enable = 1'b1;
            c.store  = (code == STRAP_HIGH);
        end else begin
            c.enable         = 1'b1; // RULE2
            c.store          = i[BIT_STORE];
            c.repeat_run     = i[BIT_REPEAT];
            c.pg_after_delay = i[BIT_PG_DELAY];
            c.long_period    = i[BIT_LONG];
            c.half_gain      = i[BIT_HALF];
        end
        return c;
    endfunction

    function automatic acs_taps_t scale(input acs_taps_t t, input logic half);
        acs_taps_t s;
        s = t;
        if (half) begin
            s.kp = t.kp >>> 1;
            s.ki = t.ki >>> 1;
            s.kd = t.kd >>> 1;
        end
        return s;
    endfunction

    logic        use_stored;
    logic [35:0] period_len;

    always_comb begin
        st_d          = st_q;
        st_d.start    = 1'b0;
        st_d.wr       = 1'b0;
        st_d.erase    = 1'b0;
        st_d.refused  = 1'b0;
        st_d.rb_valid = 1'b0;
        use_stored    = st_q.cfg.store && nvm_valid && !st_q.store_next;
        period_len    = st_q.cfg.long_period ? LONG_CYC : SHORT_CYC;

        // Strap is caught once, after reset release
        if (strap_valid && !st_q.strap_taken) begin
            st_d.cfg         = decode_strap(comp_config_strap_pin); // RULE19
            st_d.strap_taken = 1'b1;
        end else if (cfg_wr) begin
            if (output_enable && st_q.cfg.store && !cfg_wdata.store) begin
                st_d.refused = 1'b1; // RULE8
            end else begin
                st_d.cfg   = cfg_wdata; // RULE17
                st_d.erase = st_q.cfg.store && !cfg_wdata.store; // RULE8
            end
        end

        if (filter_tap_readback_cmd) begin
            st_d.rb_taps  = nvm_taps; // RULE4
            st_d.rb_valid = 1'b1;
        end

        case (st_q.state)
            S_OFF: begin
                st_d.pg = 1'b0;
                if (output_enable) begin
                    st_d.state = S_RAMP;
                end
            end
            S_RAMP: begin
                if (ramp_done) begin
                    if (!st_q.cfg.enable) begin
                        st_d.taps  = default_taps; // RULE10
                        st_d.state = S_REG;
                    end else if (use_stored) begin
                        st_d.taps       = nvm_taps; // RULE6
                        st_d.pg         = !st_q.cfg.pg_after_delay;
                        st_d.first_done = 1'b1;
                        st_d.period_cnt = 36'h0;
                        st_d.state      = st_q.cfg.pg_after_delay ? S_PGDLY : S_REG;
                    end else if (st_q.cfg.pg_after_delay) begin
                        st_d.state = S_PGDLY;
                    end else begin
                        st_d.start = 1'b1; // RULE20
                        st_d.state = S_COMP;
                    end
                end
            end
            S_PGDLY: begin
                if (pg_delay_done) begin
                    st_d.pg = 1'b1; // RULE11
                    if (use_stored) begin
                        st_d.state = S_REG;
                    end else begin
                        st_d.start = 1'b1; // RULE11
                        st_d.state = S_COMP;
                    end
                end
            end
            S_COMP: begin
                if (comp_done) begin
                    st_d.taps = scale(comp_taps, st_q.cfg.half_gain); // RULE14 RULE7
                    if (st_q.cfg.store && (!st_q.first_done || st_q.store_next)) begin
                        // Later periodic results reach the store only after a control command sets store_next
                        st_d.wr         = 1'b1; // RULE4 RULE5
                        st_d.nvm_wdata  = scale(comp_taps, st_q.cfg.half_gain);
                        st_d.store_next = 1'b0; // RULE9
                    end
                    st_d.first_done = 1'b1;
                    st_d.pg         = 1'b1; // RULE13
                    st_d.period_cnt = 36'h0;
                    st_d.state      = S_REG;
                end
            end
            S_REG: begin
                if (!st_q.cfg.enable) begin
                    st_d.pg = pg_delay_done;
                end
                if (st_q.cfg.enable && st_q.cfg.repeat_run) begin
                    st_d.period_cnt = st_q.period_cnt + 36'h1;
                end
                if (st_q.cfg.enable && ramp_done &&
                    ((st_q.cfg.repeat_run && st_q.period_cnt >= period_len - 36'h1) ||
                     (tuning_control_cmd_alias && output_enable))) begin
                    st_d.start = 1'b1; // RULE3 RULE17
                    st_d.state = S_COMP;
                end
            end
            default: begin
                st_d.state = S_OFF;
            end
        endcase

        // Set after the run's own clear, so a command on the storing edge is not lost
        if (tuning_control_cmd_alias && output_enable && st_q.cfg.store) begin
            st_d.store_next = 1'b1; // RULE9
        end

        if (!output_enable) begin
            st_d.state = S_OFF;
            st_d.pg    = 1'b0;
            st_d.start = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{state: S_OFF, cfg: CFG_RESET, period_cnt: 36'h0,
                      taps: TAPS_RESET, nvm_wdata: TAPS_RESET, rb_taps: TAPS_RESET,
                      default: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign cfg               = st_q.cfg;
    assign cfg_refused       = st_q.refused;
    assign comp_start        = st_q.start;
    assign active_taps       = st_q.taps;
    assign nvm_wr            = st_q.wr;
    assign nvm_erase         = st_q.erase;
    assign nvm_wdata         = st_q.nvm_wdata;
    assign readback_valid    = st_q.rb_valid;
    assign readback_taps     = st_q.rb_taps;
    assign power_good_output = st_q.pg;

    acs_deadtime u_deadtime (
        .clk      (clk),
        .rst_n    (rst_n),
        .pwm_high (pwm_high),
        .hs_gate  (hs_gate),
        .ls_gate  (ls_gate)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    no_run_off_a: assert property (comp_start |-> $past(cfg.enable)) // RULE1
        else $error("run started while disabled");
    run_after_ramp_a: assert property (comp_start |-> $past(ramp_done)) // RULE20
        else $error("run before ramp done");
    pg_delay_first_a: assert property (cfg.enable && cfg.pg_after_delay && $rose(power_good_output)
        |-> $past(pg_delay_done)) // RULE11
        else $error("power-good before delay");
    pg_after_comp_a: assert property (st_q.state == S_COMP && comp_done && output_enable
        |=> power_good_output) // RULE13
        else $error("power-good late after run");
    half_gain_a: assert property (st_q.state == S_COMP && comp_done && output_enable
        && cfg.half_gain |=> active_taps.kp == ($past(comp_taps.kp) >>> 1)) // RULE14
        else $error("gain scaling wrong");
    store_once_a: assert property (nvm_wr |-> !$past(st_q.first_done) || $past(st_q.store_next)) // RULE5
        else $error("periodic result stored");
    refuse_erase_a: assert property (cfg_wr && output_enable && cfg.store && !cfg_wdata.store
        && st_q.strap_taken |=> cfg_refused && cfg.store) // RULE8
        else $error("store disable not refused");
    force_store_a: assert property (tuning_control_cmd_alias && output_enable && cfg.store
        |=> st_q.store_next) // RULE9
        else $error("control command lost");
    readback_a: assert property (filter_tap_readback_cmd |=> readback_valid
        && readback_taps == $past(nvm_taps)) // RULE4
        else $error("readback wrong");

    cover_single_c: cover property (comp_start ##[1:50] nvm_wr);
    cover_delay_c: cover property (st_q.state == S_PGDLY ##1 power_good_output);
    cover_refuse_c: cover property (cfg_refused);
    cover_repeat_c: cover property (st_q.state == S_REG && cfg.repeat_run ##1 comp_start);
endmodule // acs_sequencer

// ### verification/acs_far_model.sv
// Far side: tuning engine with a settable latency, and the tap store.
// Assumes acs_pkg compiled first; every request synchronous to clk.
`timescale 1ns/1ps
module acs_far_model (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         lat,
    input  wire logic               comp_start,
    input  wire logic               nvm_wr,
    input  wire logic               nvm_erase,
    input  wire acs_pkg::acs_taps_t nvm_wdata,
    output logic                    comp_done,
    output acs_pkg::acs_taps_t      comp_taps,
    output acs_pkg::acs_taps_t      run_taps,
    output logic                    nvm_valid,
    output acs_pkg::acs_taps_t      nvm_taps
);
    import acs_pkg::*;
    logic [7:0]  wait_q;
    logic        busy_q;
    logic [7:0]  runs_q;
    logic [15:0] step;
    // Every run differs; negative kd exposes a logical shift
    assign step      = {7'h00, runs_q, 1'b0};
    // Supply held steady before each run, so results depend only on the run count
    assign run_taps  = '{16'h0100 + step, 16'h0020, 16'hFFC0 - step};
    // Taps are only valid with comp_done; otherwise the inverse shows
    assign comp_taps = comp_done ? run_taps : ~run_taps;
    // Store cleared at reset so scenarios start blank; a real one survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q    <= 1'b0;
            wait_q    <= 8'h00;
            runs_q    <= 8'h00;
            comp_done <= 1'b0;
            nvm_valid <= 1'b0;
            nvm_taps  <= '0;
        end else begin
            comp_done <= busy_q && wait_q == 8'h00;
            if (comp_start) begin
                busy_q <= 1'b1;
                wait_q <= lat;
                runs_q <= runs_q + 8'h01;
            end else if (busy_q && wait_q == 8'h00) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                wait_q <= wait_q - 8'h01;
            end
            if (nvm_wr) begin
                nvm_valid <= 1'b1;
                nvm_taps  <= nvm_wdata;
            end else if (nvm_erase) begin
                nvm_valid <= 1'b0;
                nvm_taps  <= '0;
            end
        end
    end
endmodule // acs_far_model

// ### verification/auto_compensation_sequencer_tb.sv
// Self-checking bench of the compensation sequencer with a far-side model.
// Assumes acs_pkg and acs_far_model compiled first; run periods shortened.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAITC(c) begin int k; k = 0; while (!(c) && k < 400) begin @(posedge clk); #1; \
k++; end `CHK((c), 1'b1) end
`define PULSE(s) begin @(posedge clk); s <= 1'b1; @(posedge clk); s <= 1'b0; #1; end
module auto_compensation_sequencer_tb;
    import acs_pkg::*;
    localparam int SHORT_I = 40;
    localparam int LONG_I  = 100;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [5:0] comp_config_strap_pin = 6'h00;
    logic       strap_valid = 1'b0;
    logic       cfg_wr = 1'b0;
    logic       tuning_control_cmd_alias = 1'b0;
    logic       filter_tap_readback_cmd = 1'b0;
    logic       output_enable = 1'b0;
    logic       ramp_done = 1'b0;
    logic       pg_delay_done = 1'b0;
    logic       pwm_high = 1'b0;
    logic [7:0] lat = 8'h02;
    acs_cfg_t   cfg_wdata = CFG_RESET;
    acs_cfg_t   cfg;
    acs_taps_t  default_taps = 48'h0123_0045_FF80;
    acs_taps_t  comp_taps, run_taps, nvm_taps, nvm_wdata, active_taps, readback_taps;
    logic       cfg_refused, comp_start, nvm_wr, nvm_erase, readback_valid, comp_done;
    logic       power_good_output, hs_gate, ls_gate, nvm_valid;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         starts, writes, refused, erases;

    always #2.5 clk = ~clk;

    acs_sequencer #(.SHORT_CYC(36'(SHORT_I)), .LONG_CYC(36'(LONG_I))) dut (
        .clk(clk), .rst_n(rst_n), .comp_config_strap_pin(comp_config_strap_pin),
        .strap_valid(strap_valid), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .tuning_control_cmd_alias(tuning_control_cmd_alias),
        .filter_tap_readback_cmd(filter_tap_readback_cmd), .output_enable(output_enable),
        .ramp_done(ramp_done), .pg_delay_done(pg_delay_done), .comp_done(comp_done),
        .comp_taps(comp_taps), .nvm_valid(nvm_valid), .nvm_taps(nvm_taps),
        .default_taps(default_taps), .pwm_high(pwm_high), .cfg(cfg),
        .cfg_refused(cfg_refused), .comp_start(comp_start), .active_taps(active_taps),
        .nvm_wr(nvm_wr), .nvm_erase(nvm_erase), .nvm_wdata(nvm_wdata),
        .readback_valid(readback_valid), .readback_taps(readback_taps),
        .power_good_output(power_good_output), .hs_gate(hs_gate), .ls_gate(ls_gate));

    acs_far_model far (.clk(clk), .rst_n(rst_n), .lat(lat), .comp_start(comp_start),
        .nvm_wr(nvm_wr), .nvm_erase(nvm_erase), .nvm_wdata(nvm_wdata),
        .comp_done(comp_done), .comp_taps(comp_taps), .run_taps(run_taps),
        .nvm_valid(nvm_valid), .nvm_taps(nvm_taps));

    // Pulse counters read the previous cycle's outputs, so they lag one edge
    always @(posedge clk) begin
        if (!rst_n) begin
            starts = 0;
            writes = 0;
            refused = 0;
            erases = 0;
        end else begin
            starts += int'(comp_start);
            writes += int'(nvm_wr);
            refused += int'(cfg_refused);
            erases += int'(nvm_erase);
        end
    end

    function automatic acs_taps_t half(input acs_taps_t t);
        return '{t.kp >>> 1, t.ki >>> 1, t.kd >>> 1};
    endfunction

    task automatic do_reset(input logic [5:0] code);
        @(posedge clk);
        rst_n <= 1'b0;
        output_enable <= 1'b0;
        ramp_done <= 1'b0;
        pg_delay_done <= 1'b0;
        comp_config_strap_pin <= code;
        strap_valid <= 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic write_cfg(input logic [5:0] v);
        @(posedge clk);
        cfg_wdata <= acs_cfg_t'(v);
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic power_up();
        int s;
        s = starts;
        @(posedge clk);
        output_enable <= 1'b1;
        repeat (10) @(posedge clk);
        ramp_done <= 1'b1;
        #1;
        `CHK(starts, s)
    endtask

    task automatic gap_ok(input int p);
        int g;
        g = 0;
        while (!comp_start && g < 500) begin
            @(posedge clk);
            #1;
            g++;
        end
        `CHK(g inside {[p - 3:p + 2]}, 1'b1)
    endtask

    task automatic t_strap();
        acs_cfg_t   e;
        logic [4:0] i;
        for (int c = 0; c < 35; c++) begin
            i = 5'(c - 3);
            e = acs_cfg_t'({1'b1, i[0], i[1], i[2], i[3], i[4]});
            if (c < 3) e = acs_cfg_t'({1'b1, c == 2, 4'h0});
            if (c == 0) e = CFG_RESET;
            do_reset(6'(c));
            `CHK(cfg, e)
            @(posedge clk);
            comp_config_strap_pin <= 6'(c ^ 5);
            repeat (3) @(posedge clk);
            #1;
            `CHK(cfg, e)
        end
    endtask

    task automatic t_single();
        acs_taps_t h;
        do_reset(6'h14);
        lat <= 8'h1E;
        power_up();
        `WAITC(comp_start)
        `CHK(power_good_output, 1'b0)
        `WAITC(power_good_output)
        h = half(run_taps);
        `CHK(active_taps, h)
        repeat (2) @(posedge clk);
        `PULSE(filter_tap_readback_cmd)
        `CHK({writes, nvm_taps}, {32'h1, h})
        `CHK({readback_valid, readback_taps}, {1'b1, h})
        @(posedge clk);
        output_enable <= 1'b0;
        ramp_done <= 1'b0;
        repeat (3) @(posedge clk);
        power_up();
        `WAITC(power_good_output)
        `CHK({starts, active_taps}, {32'h1, h})
        write_cfg(6'h21);
        `CHK({refused, cfg.store}, {32'h1, 1'b1})
        @(posedge clk);
        output_enable <= 1'b0;
        write_cfg(6'h21);
        `CHK({erases, cfg.store, nvm_valid}, {32'h1, 2'h0})
    endtask

    task automatic t_pg_delay();
        do_reset(6'h07);
        lat <= 8'h02;
        power_up();
        repeat (10) @(posedge clk);
        #1;
        `CHK({starts, power_good_output}, {32'h0, 1'b0})
        @(posedge clk);
        pg_delay_done <= 1'b1;
        #1;
        `WAITC(comp_start)
        `CHK(power_good_output, 1'b1)
        `WAITC(comp_done)
        repeat (2) @(posedge clk);
        #1;
        `CHK({writes, active_taps}, {32'h0, run_taps})
    endtask

    task automatic t_disabled();
        do_reset(6'h00);
        power_up();
        repeat (20) @(posedge clk);
        #1;
        `CHK({starts, power_good_output}, {32'h0, 1'b0})
        `CHK(active_taps, default_taps)
        @(posedge clk);
        pg_delay_done <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(power_good_output, 1'b1)
    endtask

    task automatic t_repeat();
        do_reset(6'h00);
        write_cfg(6'h38);
        lat <= 8'h03;
        power_up();
        `WAITC(power_good_output)
        gap_ok(SHORT_I);
        `WAITC(comp_done)
        repeat (2) @(posedge clk);
        #1;
        `CHK({writes, active_taps}, {32'h1, run_taps})
        `PULSE(tuning_control_cmd_alias)
        `WAITC(writes == 2)
        `CHK(nvm_taps, run_taps)
        write_cfg(6'h3A);
        `WAITC(comp_done)
        gap_ok(LONG_I);
    endtask

    task automatic t_dead();
        int z;
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            pwm_high <= 1'(v);
            z = 0;
            repeat (20) begin
                @(posedge clk);
                #1;
                z += int'(!hs_gate && !ls_gate);
                `CHK(hs_gate && ls_gate, 1'b0)
            end
            `CHK(z, int'(DEAD_CYC) + 1)
            `CHK({hs_gate, ls_gate}, {1'(v), ~1'(v)})
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        t_strap();
        t_single();
        t_pg_delay();
        t_disabled();
        t_repeat();
        t_dead();
        tally_and_finish();
    end

    // Whole run is under two thousand cycles; this leaves ample margin
    initial begin
        #100_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // auto_compensation_sequencer_tb
